// >>> hw/sfcp_pkg.sv
package sfcp_pkg;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0b;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'h52;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
  localparam logic [7:0] OP_BYTE_PROG = 8'h02;
  localparam logic [7:0] OP_AUTO_PROG = 8'had;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE_ENABLE = 8'h50;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_WRITE_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] OP_READY_OUT_ENABLE = 8'h70;
  localparam logic [7:0] OP_READY_OUT_DISABLE = 8'h80;
  localparam logic [7:0] OP_PAUSE_PIN_ENABLE = 8'haa;
  localparam int unsigned BITS_PER_CYCLE = 8;
  localparam int unsigned ADDR_BYTES = 3;
  localparam int unsigned STATUS_LOCK_POS = 7;
  localparam int unsigned STATUS_AUTO_POS = 6;
  localparam int unsigned STATUS_LEVEL_POS = 2;
  localparam int unsigned STATUS_LATCH_POS = 1;
  localparam logic [2:0] LEVEL_RESET = 3'h3;
  localparam logic PROTECT_LOCK_RESET = 1'b0;
  localparam logic [1:0] DENS_512K = 2'h0;
  localparam logic [1:0] DENS_1M = 2'h1;
  localparam logic [1:0] DENS_2M = 2'h2;
  localparam logic [1:0] DENS_4M = 2'h3;

  typedef enum logic [1:0] {
    SFCP_ERASE_SECTOR, SFCP_ERASE_BLOCK, SFCP_ERASE_CHIP, SFCP_PROGRAM
  } sfcp_req_e;

  typedef struct packed {
    sfcp_req_e kind;
    logic [23:0] addr;
    logic [7:0] data;
  } sfcp_req_s;
endpackage

// >>> hw/sfcp_core.sv
// Notes on behaviour
// - Status shows auto-increment mode; single-byte mode after power-up.
// - Status write takes new levels only when protect pin high or lock zero.
// - Full erase runs only with all level bits zero, else ignored.
// - Protect pin low and lock one freezes lock and level bits.
// - Protect pin high makes the lock bit irrelevant.
// - Lock bit is zero after power-up.
// - 512 Kbit: 00 none, 01 top quarter, 10 top half, 11 all.
// - 1 Mbit: 00 none, 01 top quarter, 10 top half, 11 all.
// - 2 Mbit: 00 none, 01 top quarter, 10 top half, 11 all.
// - 4 Mbit: eighth, quarter, half; top level bit set protects all.
// - Lower two level bits are ones after power-up.
// - Opcode, address and data cycles are eight bits each.
// - Select fall starts a command; input sampled on clock rise, MSB first.
// - Select rising mid-cycle abandons the command, back to standby.
// - Read 03 and fast read 0b take three address bytes, fast adds dummy.
// - Erases 20 sector, 52 block with address; 60 or c7 full array.
// - Program 02 one byte; ad auto-increment with two or more bytes.
// - Opcode 70 enables ready/busy output during auto-increment program.
// - Opcode 80 disables ready/busy output during auto-increment program.
// - Opcode aa turns the shared reset pin into the pause input.
// - Status read repeats the status byte until select rises.
// - Status write needs status-write enable or write-latch set first.
module sfcp_core (
  // System
  input wire logic clk,
  input wire logic rst,
  // Serial link pins
  input wire logic chip_select_n,
  input wire logic serial_clock,
  input wire logic serial_in,
  input wire logic write_protect_n,
  output logic serial_out,
  output logic serial_out_oe_n,
  // Configuration and engine status
  input wire logic [1:0] density,
  input wire logic engine_busy,
  input wire logic auto_done,
  // Array request stream
  output logic req_valid,
  input wire logic req_ready,
  output sfcp_pkg::sfcp_req_s req,
  // Status view
  output logic [7:0] status,
  output logic auto_increment_program_mode,
  output logic ready_busy_indicator_en,
  output logic pause_pin_mode,
  output logic [23:0] protect_base,
  output logic protect_any
);
  typedef enum logic [2:0] {
    ST_OPCODE, ST_ADDR, ST_DUMMY, ST_DATA, ST_STATUS_OUT, ST_IGNORE
  } sfcp_state_e;

  logic [1:0] cs_sync, sck_sync, si_sync, wp_sync;
  logic sck_prev, cs_prev;
  logic [7:0] shift;
  logic [2:0] bit_cnt;
  logic [1:0] addr_cnt;
  logic [7:0] opcode;
  logic [23:0] addr;
  sfcp_state_e state;
  logic write_latch, status_write_ok;
  logic protect_lock_bit;
  logic [2:0] level;
  logic [7:0] out_shift;
  logic sck_rise, sck_fall, cs_fall, cs_high, byte_done;
  logic [7:0] rx_byte;
  logic push, req_ready_int;
  sfcp_pkg::sfcp_req_s push_req;
  sfcp_pkg::sfcp_req_s buf0, buf1;
  logic [1:0] buf_cnt;

  // Two-flop sync of every pin before use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_sync <= 2'h3;
      sck_sync <= 2'h0;
      si_sync <= 2'h0;
      wp_sync <= 2'h3;
      sck_prev <= 1'b0;
      cs_prev <= 1'b1;
    end else begin
      cs_sync <= {cs_sync[0], chip_select_n};
      sck_sync <= {sck_sync[0], serial_clock};
      si_sync <= {si_sync[0], serial_in};
      wp_sync <= {wp_sync[0], write_protect_n};
      sck_prev <= sck_sync[1];
      cs_prev <= cs_sync[1];
    end
  end

  assign cs_high = cs_sync[1];
  assign sck_rise = sck_sync[1] & ~sck_prev & ~cs_high;
  assign sck_fall = ~sck_sync[1] & sck_prev & ~cs_high;
  assign cs_fall = ~cs_sync[1] & cs_prev;
  assign rx_byte = {shift[6:0], si_sync[1]};
  assign byte_done = sck_rise && (bit_cnt == 3'(sfcp_pkg::BITS_PER_CYCLE - 1));

  function automatic logic [23:0] size_of(input logic [1:0] d);
    unique case (d)
      sfcp_pkg::DENS_512K: size_of = 24'h010000;
      sfcp_pkg::DENS_1M: size_of = 24'h020000;
      sfcp_pkg::DENS_2M: size_of = 24'h040000;
      default: size_of = 24'h080000;
    endcase
  endfunction

  function automatic logic addr_opcode(input logic [7:0] op);
    addr_opcode = (op == sfcp_pkg::OP_READ) || (op == sfcp_pkg::OP_FAST_READ)
      || (op == sfcp_pkg::OP_SECTOR_ERASE) || (op == sfcp_pkg::OP_BLOCK_ERASE)
      || (op == sfcp_pkg::OP_BYTE_PROG) || (op == sfcp_pkg::OP_AUTO_PROG);
  endfunction

  // Protected region start from level and density
  always_comb begin
    logic [23:0] sz;
    sz = size_of(density);
    protect_any = 1'b1;
    protect_base = 24'h000000;
    if (density == sfcp_pkg::DENS_4M) begin
      unique case (level)
        3'h0: protect_any = 1'b0;
        3'h1: protect_base = sz - (sz >> 3);
        3'h2: protect_base = sz - (sz >> 2);
        3'h3: protect_base = sz >> 1;
        default: protect_base = 24'h000000;
      endcase
    end else begin
      unique case (level[1:0])
        2'h0: protect_any = 1'b0;
        2'h1: protect_base = sz - (sz >> 2);
        2'h2: protect_base = sz >> 1;
        2'h3: protect_base = 24'h000000;
      endcase
    end
  end

  // Bit counter and shift register; select high returns to standby
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift <= 8'h00;
      bit_cnt <= 3'h0;
    end else if (cs_high || cs_fall) begin
      bit_cnt <= 3'h0;
    end else if (sck_rise) begin
      shift <= rx_byte;
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // Command sequencing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_OPCODE;
      opcode <= 8'h00;
      addr <= 24'h000000;
      addr_cnt <= 2'h0;
    end else if (cs_high) begin
      state <= ST_OPCODE;
    end else if (byte_done) begin
      unique case (state)
        ST_OPCODE: begin
          opcode <= rx_byte;
          addr_cnt <= 2'h0;
          if (addr_opcode(rx_byte))
            state <= ST_ADDR;
          else if (rx_byte == sfcp_pkg::OP_STATUS_READ)
            state <= ST_STATUS_OUT;
          else if (rx_byte == sfcp_pkg::OP_STATUS_WRITE)
            state <= ST_DATA;
          else
            state <= ST_IGNORE;
        end
        ST_ADDR: begin
          addr <= {addr[15:0], rx_byte};
          addr_cnt <= addr_cnt + 2'h1;
          if (addr_cnt == 2'(sfcp_pkg::ADDR_BYTES - 1)) begin
            if (opcode == sfcp_pkg::OP_FAST_READ)
              state <= ST_DUMMY;
            else if (opcode == sfcp_pkg::OP_BYTE_PROG ||
                     opcode == sfcp_pkg::OP_AUTO_PROG)
              state <= ST_DATA;
            else
              state <= ST_IGNORE;
          end
        end
        ST_DUMMY: state <= ST_IGNORE;
        ST_DATA: begin
          if (opcode == sfcp_pkg::OP_AUTO_PROG)
            addr <= addr + 24'h1;
          else
            state <= ST_IGNORE;
        end
        ST_STATUS_OUT: state <= ST_STATUS_OUT;
        ST_IGNORE: state <= ST_IGNORE;
      endcase
    end
  end

  // Erases and the byte-program latch clear fire on select rising after a whole last byte
  logic cmd_end;
  // Empty select pulses must not replay the previous opcode
  assign cmd_end = cs_high && !cs_prev && bit_cnt == 3'h0 &&
    state != ST_OPCODE;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      write_latch <= 1'b0;
      status_write_ok <= 1'b0;
      protect_lock_bit <= sfcp_pkg::PROTECT_LOCK_RESET;
      level <= sfcp_pkg::LEVEL_RESET;
      ready_busy_indicator_en <= 1'b0;
      pause_pin_mode <= 1'b0;
    end else if (byte_done && state == ST_OPCODE) begin
      unique case (rx_byte)
        sfcp_pkg::OP_WRITE_LATCH_SET: write_latch <= 1'b1;
        sfcp_pkg::OP_WRITE_LATCH_CLEAR: write_latch <= 1'b0;
        sfcp_pkg::OP_STATUS_WRITE_ENABLE: status_write_ok <= 1'b1;
        sfcp_pkg::OP_READY_OUT_ENABLE: ready_busy_indicator_en <= 1'b1;
        sfcp_pkg::OP_READY_OUT_DISABLE: ready_busy_indicator_en <= 1'b0;
        sfcp_pkg::OP_PAUSE_PIN_ENABLE: pause_pin_mode <= 1'b1;
        default: ;
      endcase
    end else if (byte_done && state == ST_DATA &&
                 opcode == sfcp_pkg::OP_STATUS_WRITE) begin
      if (write_latch || status_write_ok) begin
        if (wp_sync[1] || !protect_lock_bit) begin
          protect_lock_bit <= rx_byte[sfcp_pkg::STATUS_LOCK_POS];
          level <= rx_byte[sfcp_pkg::STATUS_LEVEL_POS +: 3];
        end
      end
      write_latch <= 1'b0;
      status_write_ok <= 1'b0;
    end else if (push && req_ready_int && push_req.kind != sfcp_pkg::SFCP_PROGRAM)
      write_latch <= 1'b0;
    else if (cmd_end && opcode == sfcp_pkg::OP_BYTE_PROG)
      write_latch <= 1'b0;
    else if (auto_done)
      write_latch <= 1'b0;
  end

  // Auto-increment mode tracks the engine's programming session
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      auto_increment_program_mode <= 1'b0;
    else if (byte_done && state == ST_DATA && write_latch &&
             opcode == sfcp_pkg::OP_AUTO_PROG)
      auto_increment_program_mode <= 1'b1;
    else if (auto_done)
      auto_increment_program_mode <= 1'b0;
  end

  // Request generation toward the array engine
  always_comb begin
    push = 1'b0;
    push_req = '{kind: sfcp_pkg::SFCP_PROGRAM, addr: addr, data: rx_byte};
    if (byte_done && state == ST_DATA && write_latch &&
        (opcode == sfcp_pkg::OP_BYTE_PROG ||
         opcode == sfcp_pkg::OP_AUTO_PROG)) begin
      push = 1'b1;
    end else if (cmd_end && write_latch) begin
      if (opcode == sfcp_pkg::OP_CHIP_ERASE_A ||
          opcode == sfcp_pkg::OP_CHIP_ERASE_B) begin
        push = (level == 3'h0);
        push_req.kind = sfcp_pkg::SFCP_ERASE_CHIP;
      end else if (opcode == sfcp_pkg::OP_SECTOR_ERASE &&
                   state == ST_IGNORE) begin
        push = 1'b1;
        push_req.kind = sfcp_pkg::SFCP_ERASE_SECTOR;
      end else if (opcode == sfcp_pkg::OP_BLOCK_ERASE &&
                   state == ST_IGNORE) begin
        push = 1'b1;
        push_req.kind = sfcp_pkg::SFCP_ERASE_BLOCK;
      end
    end
  end

  // Two-entry buffer; the link cannot wait, so a push into a full one is lost
  assign req_ready_int = (buf_cnt != 2'h2);
  assign req_valid = (buf_cnt != 2'h0);
  assign req = buf0;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buf_cnt <= 2'h0;
      buf0 <= '0;
      buf1 <= '0;
    end else begin
      unique case ({push && req_ready_int, req_valid && req_ready})
        2'b10: begin
          if (buf_cnt == 2'h0)
            buf0 <= push_req;
          else
            buf1 <= push_req;
          buf_cnt <= buf_cnt + 2'h1;
        end
        2'b01: begin
          buf0 <= buf1;
          buf_cnt <= buf_cnt - 2'h1;
        end
        2'b11: begin
          if (buf_cnt == 2'h1)
            buf0 <= push_req;
          else begin
            buf0 <= buf1;
            buf1 <= push_req;
          end
        end
        default: ;
      endcase
    end
  end

  assign status = {protect_lock_bit, auto_increment_program_mode, 1'b0,
                   level, write_latch, engine_busy};

  // Status output changes on clock fall, MSB first; ready/busy follows the engine
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_shift <= 8'h00;
      serial_out <= 1'b0;
      serial_out_oe_n <= 1'b1;
    end else if (cs_high) begin
      serial_out_oe_n <= 1'b1;
      serial_out <= 1'b0;
    end else if (state == ST_STATUS_OUT && sck_fall) begin
      if (bit_cnt == 3'h0) begin
        serial_out <= status[7];
        out_shift <= {status[6:0], 1'b0};
      end else begin
        serial_out <= out_shift[7];
        out_shift <= {out_shift[6:0], 1'b0};
      end
      serial_out_oe_n <= 1'b0;
    end else if (state != ST_STATUS_OUT && ready_busy_indicator_en &&
                 auto_increment_program_mode) begin
      // Ready reads high; driven only while selected
      serial_out <= ~engine_busy;
      serial_out_oe_n <= 1'b0;
    end
  end
endmodule

// >>> verif/sfcp_props.sv
module sfcp_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched ports
  input wire logic write_protect_n,
  input wire logic [1:0] density,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire sfcp_pkg::sfcp_req_s req,
  input wire logic [7:0] status,
  input wire logic auto_increment_program_mode,
  input wire logic [23:0] protect_base,
  input wire logic protect_any
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  req_hold_a: assert property (req_valid && !req_ready |=>
    req_valid && $stable(req)) else $error("stalled request moved");
  erase_level_a: assert property (req_valid &&
    req.kind == sfcp_pkg::SFCP_ERASE_CHIP |-> status[4:2] == 3'h0)
    else $error("full erase while protected");
  lock_hold_a: assert property (!write_protect_n && status[7] |=>
    status[7] && $stable(status[4:2])) else $error("locked bits moved");
  auto_view_a: assert property ($rose(status[6]) |->
    auto_increment_program_mode && req_valid &&
    req.kind == sfcp_pkg::SFCP_PROGRAM) else $error("mode bit");
  reset_val_a: assert property ($past(rst) |->
    !status[7] && status[3:2] == 2'h3) else $error("bad reset status");
  no_level_a: assert property (status[4:2] == 3'h0 |->
    !protect_any) else $error("protected at level zero");
  full_small_a: assert property (status[4:2] == 3'h3 &&
    density != sfcp_pkg::DENS_4M |-> protect_any && protect_base == 24'h0)
    else $error("small part not fully protected");
  full_big_a: assert property (status[4] &&
    density == sfcp_pkg::DENS_4M |-> protect_any && protect_base == 24'h0)
    else $error("large part not fully protected");
endmodule

// >>> verif/sfcp_host.sv
module sfcp_host (
  // Clock
  input wire logic clk,
  // Link pins
  output logic chip_select_n,
  output logic serial_clock,
  output logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [55:0] sh;
  logic [15:0] got;
  initial begin
    chip_select_n = 1'b1;
    serial_clock = 1'b0;
    serial_in = 1'b0;
  end
  // Opcode, n bytes; nb below 8 cuts the last byte short (the opcode when n is 0)
  task automatic send(input logic [7:0] op, input int n = 0,
      input logic [47:0] arg = '0, input int nb = 8);
    @(posedge clk);
    chip_select_n <= 1'b0;
    sh = {op, arg << (48 - 8 * n)};
    for (int i = 0; i < 8 * n + nb; i++) begin
      serial_in <= sh[55 - i];
      repeat (4) @(posedge clk);
      // Released line reads inverted so a missing drive shows
      got = {got[14:0], serial_out_oe_n ? ~serial_out : serial_out};
      serial_clock <= 1'b1;
      repeat (4) @(posedge clk);
      serial_clock <= 1'b0;
    end
    repeat (4) @(posedge clk);
    chip_select_n <= 1'b1;
    serial_in <= ~serial_in;
    repeat (8) @(posedge clk);
  endtask
endmodule

// >>> verif/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, chip_select_n, serial_clock, serial_in, serial_out;
  logic write_protect_n, serial_out_oe_n, engine_busy, auto_done;
  logic req_valid, req_ready, auto_increment_program_mode;
  logic ready_busy_indicator_en, pause_pin_mode, protect_any;
  logic [1:0] density;
  logic [7:0] status;
  logic [23:0] protect_base;
  sfcp_pkg::sfcp_req_s req;
  int err_total;
  int n_compared;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
  $display("Error at %0t: got %h exp %h", $time, a, b); end end
  sfcp_core dut_u (.*);
  sfcp_host host_u (.*);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wen();
    host_u.send(sfcp_pkg::OP_WRITE_LATCH_SET);
  endtask
  task automatic wstat(input logic [7:0] v);
    wen();
    host_u.send(sfcp_pkg::OP_STATUS_WRITE, 1, {40'h0, v});
  endtask
  task automatic quiet();
    repeat (100) @(posedge clk);
    `CHK(req_valid, 1'b0)
  endtask
  task automatic take(input sfcp_pkg::sfcp_req_e k, input logic [23:0] a,
      input logic [7:0] d);
    int i;
    // Step past any pop launched by the edge we came in on
    #1;
    for (i = 0; i < 400 && req_valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 400) begin
      err_total++;
      print_verdict();
    end
    `CHK(req.kind, k)
    if (k != sfcp_pkg::SFCP_ERASE_CHIP) `CHK(req.addr, a)
    if (k == sfcp_pkg::SFCP_PROGRAM) `CHK(req.data, d)
    @(posedge clk);
    req_ready <= 1'b1;
    @(posedge clk);
    req_ready <= 1'b0;
  endtask
  task automatic t_levels();
    logic [23:0] sz;
    int s;
    for (int lv = 0; lv < 8; lv++) begin
      wstat(8'(lv << 2));
      `CHK(status[4:2], 3'(lv))
      for (int d = 0; d < 4; d++) begin
        if (d < 3 && lv > 3) continue;
        @(posedge clk);
        density <= 2'(d);
        @(posedge clk);
        #1;
        sz = 24'h10000 << d;
        s = (d == 3) ? ((lv > 3) ? 0 : 4 - lv) : 3 - lv;
        `CHK(protect_any, lv != 0)
        if (lv != 0) `CHK(protect_base, sz - (sz >> s))
      end
    end
    $display("level test done");
  endtask
  task automatic t_lock();
    @(posedge clk);
    write_protect_n <= 1'b0;
    wstat(8'h84);
    `CHK(status[7:2], 6'h21)
    wstat(8'h08);
    `CHK(status[7:2], 6'h21)
    @(posedge clk);
    write_protect_n <= 1'b1;
    wstat(8'h08);
    `CHK(status[7:2], 6'h02)
    host_u.send(sfcp_pkg::OP_STATUS_WRITE_ENABLE);
    host_u.send(sfcp_pkg::OP_STATUS_WRITE, 1, 48'h0);
    `CHK(status[7:2], 6'h00)
    $display("lock test done");
  endtask
  task automatic t_abort();
    host_u.send(sfcp_pkg::OP_WRITE_LATCH_SET, 0, 48'h0, 5);
    `CHK(status[1], 1'b0)
    wen();
    host_u.send(8'hff);
    host_u.send(8'h3c, 2, 48'h1234);
    host_u.send(sfcp_pkg::OP_READ, 4, 48'h01234500);
    host_u.send(sfcp_pkg::OP_FAST_READ, 5, 48'h0123450000);
    `CHK(req_valid, 1'b0)
    engine_busy <= 1'b1;
    @(posedge clk);
    `CHK(status, 8'h03)
    host_u.send(sfcp_pkg::OP_STATUS_READ, 2);
    `CHK(host_u.got, 16'h0303)
    `CHK(serial_out_oe_n, 1'b1)
    host_u.send(sfcp_pkg::OP_WRITE_LATCH_CLEAR);
    `CHK(status[1], 1'b0)
    engine_busy <= 1'b0;
    $display("abort test done");
  endtask
  task automatic t_prog();
    host_u.send(sfcp_pkg::OP_READY_OUT_ENABLE);
    `CHK(ready_busy_indicator_en, 1'b1)
    wen();
    host_u.send(sfcp_pkg::OP_BYTE_PROG, 4, 48'h00a1b25a);
    take(sfcp_pkg::SFCP_PROGRAM, 24'h00a1b2, 8'h5a);
    wen();
    host_u.send(sfcp_pkg::OP_AUTO_PROG, 5, 48'h0001001122);
    `CHK(auto_increment_program_mode, 1'b1)
    engine_busy <= 1'b1;
    host_u.send(8'hff, 1);
    `CHK(host_u.got, 16'h0000)
    engine_busy <= 1'b0;
    take(sfcp_pkg::SFCP_PROGRAM, 24'h000100, 8'h11);
    take(sfcp_pkg::SFCP_PROGRAM, 24'h000101, 8'h22);
    quiet();
    auto_done <= 1'b1;
    @(posedge clk);
    auto_done <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(auto_increment_program_mode, 1'b0)
    host_u.send(sfcp_pkg::OP_READY_OUT_DISABLE);
    `CHK(ready_busy_indicator_en, 1'b0)
    host_u.send(sfcp_pkg::OP_PAUSE_PIN_ENABLE);
    `CHK(pause_pin_mode, 1'b1)
    $display("program test done");
  endtask
  task automatic t_erase();
    wen();
    host_u.send(sfcp_pkg::OP_SECTOR_ERASE, 3, 48'h012000);
    take(sfcp_pkg::SFCP_ERASE_SECTOR, 24'h012000, 8'h0);
    wen();
    host_u.send(sfcp_pkg::OP_BLOCK_ERASE, 3, 48'h018000);
    take(sfcp_pkg::SFCP_ERASE_BLOCK, 24'h018000, 8'h0);
    wstat(8'h04);
    wen();
    host_u.send(sfcp_pkg::OP_CHIP_ERASE_A);
    quiet();
    wstat(8'h00);
    for (int i = 0; i < 2; i++) begin
      wen();
      host_u.send(i ? sfcp_pkg::OP_CHIP_ERASE_B : sfcp_pkg::OP_CHIP_ERASE_A);
      take(sfcp_pkg::SFCP_ERASE_CHIP, 24'h0, 8'h0);
    end
    $display("erase test done");
  endtask
  initial begin
    err_total = 0;
    n_compared = 0;
    rst = 1'b1;
    write_protect_n = 1'b1;
    engine_busy = 1'b0;
    auto_done = 1'b0;
    req_ready = 1'b0;
    density = sfcp_pkg::DENS_4M;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(status, 8'h0c)
    $display("reset test done");
    t_levels();
    t_lock();
    t_abort();
    t_prog();
    t_erase();
    print_verdict();
  end
endmodule
bind sfcp_core sfcp_props p_u (.*);
